// file: rtl/clk_power_consts.svh
// Constants for the clock generation and power-state control block.
`ifndef CLK_POWER_CONSTS_SVH
`define CLK_POWER_CONSTS_SVH
`define OFF_PLL_CONTROL 4'h0
`define OFF_CLOCK_DIVIDE 4'h1
`define OFF_REGULATOR_CONTROL 4'h2
`define OFF_POWER_CONTROL 4'h3
`define OFF_STATUS 4'h4
`define PLL_MULT_LSB 0
`define PLL_BYPASS_BIT 8
`define PLL_DISABLE_BIT 9
`define PLL_MULT_RESET 6'h0A
`define CORE_DIV_LSB 4
`define SYS_DIV_LSB 0
`define CORE_DIV_RESET 2'h0
`define SYS_DIV_RESET 4'h5
`define REG_SWITCH_LSB 0
`define REG_LEVEL_LSB 4
`define REG_SWITCH_RESET 2'h1
`define REG_LEVEL_RESET 4'hB
`define REG_STEP_MV 50
`define REG_BASE_MV 650
`define PWR_SLEEP_BIT 0
`define PWR_DEEP_BIT 1
`define PWR_RELOCK_BIT 2
`define PLL_LOCK_US 200
`define MCLK_MHZ 20
`define PLL_LOCK_CYCLES ((`PLL_LOCK_US) * (`MCLK_MHZ))
`define ADDR_UNMAPPED_DATA 32'hDEADBEEF
`endif

// file: rtl/clk_power_ctrl.sv
// Clock generation, divider and power-state control with an Avalon-MM register port.
// Operation
// - Deep sleep left by reset interrupt with bypass clear enters relock, then full-on mode.
// - Deep sleep left by reset interrupt with bypass set enters active mode.
// - Regulator level code sets core supply in 50 mV steps.
// - Hibernate restarts on RTC wakeup or reset pin, then boot begins.
// - PLL multiplies input clock by programmable factor 1 to 63.
// - Multiplier resets to 10 until software changes it.
// - Clock divide writes change derived frequencies at the end of the current divided period, no relock.
// - All peripherals run from the system clock only.
// - System divide field divides PLL output by its value, 1 to 15.
// - System divide change needs no PLL lock wait.
// - Core divide codes 0 to 3 divide by 1, 2, 4, 8.
// - Active mode runs clocks at input rate; multiplier applies at full-on.
// - Wakeup from sleep samples bypass bit to pick the resumed mode.
// - Writing zero to regulator switching field in full-on or active mode enters hibernate, stopping clocks.
`include "clk_power_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module clk_power_ctrl
  import clk_power_pkg::*;
#(
  parameter int LOCK_CYCLES = `PLL_LOCK_CYCLES,
  parameter int VCO_PER_INPUT = 1
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wakeup_i,
  input wire logic reset_interrupt_i,
  input wire logic rtc_wakeup_i,
  input wire logic reset_pin_i,
  output logic core_clock_en_o,
  output logic sys_clock_en_o,
  output logic peripheral_clock_en_o,
  output logic [5:0] vco_mult_o,
  output logic pll_bypass_o,
  output logic regulator_on_o,
  output logic [3:0] core_level_code_o,
  output logic [11:0] core_level_mv_o,
  output logic boot_start_o,
  output logic [2:0] power_mode_o
);
  pll_cfg_t pll_reg;
  div_cfg_t div_reg;
  logic [1:0] reg_switch_reg;
  logic [3:0] reg_level_reg;
  logic [5:0] mult_applied_reg;
  power_mode_t mode_reg;
  power_mode_t mode_next;
  logic [31:0] lock_count_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic boot_reg;
  logic [11:0] level_mv_reg;

  // Bus decode; each access is answered one cycle after it is presented.
  logic access;
  logic wr_pll;
  logic wr_div;
  logic wr_reg;
  logic wr_pwr;
  logic hit;
  logic [31:0] read_mux;
  logic [5:0] mult_wr;
  logic relock_req;
  assign access = (avs_read || avs_write) && !ack_reg;
  assign wr_pll = access && avs_write && (avs_address == `OFF_PLL_CONTROL);
  assign wr_div = access && avs_write && (avs_address == `OFF_CLOCK_DIVIDE);
  assign wr_reg = access && avs_write && (avs_address == `OFF_REGULATOR_CONTROL);
  assign wr_pwr = access && avs_write && (avs_address == `OFF_POWER_CONTROL);
  assign hit = (avs_address <= `OFF_STATUS);
  assign avs_waitrequest = !ack_reg;
  assign avs_readdata = readdata_reg;
  // Multiplier zero is illegal; it is held at one.
  assign mult_wr = (avs_writedata[5:0] == 6'h00) ? 6'h01 : avs_writedata[5:0];
  assign relock_req = wr_pwr && avs_writedata[`PWR_RELOCK_BIT] && avs_byteenable[0];

  // Read data selection.
  always_comb begin
    read_mux = `ADDR_UNMAPPED_DATA;
    unique case (avs_address)
      `OFF_PLL_CONTROL: read_mux = {22'h0, pll_reg.disable_pll, pll_reg.bypass, 2'h0, pll_reg.mult};
      `OFF_CLOCK_DIVIDE: read_mux = {26'h0, div_reg.core_div, div_reg.sys_div};
      `OFF_REGULATOR_CONTROL: read_mux = {24'h0, reg_level_reg, 2'h0, reg_switch_reg};
      `OFF_POWER_CONTROL: read_mux = 32'h0;
      `OFF_STATUS: read_mux = {20'h0, mult_applied_reg, 3'h0, 3'(mode_reg)};
      default: read_mux = `ADDR_UNMAPPED_DATA;
    endcase
  end

  // Bus handshake register; unmapped reads return a marker, unmapped writes are dropped.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0;
    end else if (ce_i) begin
      ack_reg <= access;
      if (access && avs_read) begin
        readdata_reg <= hit ? read_mux : `ADDR_UNMAPPED_DATA;
      end
    end
  end

  // Configuration registers; divider writes take effect without any relock.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pll_reg.mult <= `PLL_MULT_RESET;
      pll_reg.bypass <= 1'b0;
      pll_reg.disable_pll <= 1'b0;
      div_reg.core_div <= `CORE_DIV_RESET;
      div_reg.sys_div <= `SYS_DIV_RESET;
      reg_switch_reg <= `REG_SWITCH_RESET;
      reg_level_reg <= `REG_LEVEL_RESET;
    end else if (ce_i) begin
      if (wr_pll && avs_byteenable[0]) begin
        pll_reg.mult <= mult_wr;
      end
      if (wr_pll && avs_byteenable[1]) begin
        pll_reg.bypass <= avs_writedata[`PLL_BYPASS_BIT];
        pll_reg.disable_pll <= avs_writedata[`PLL_DISABLE_BIT];
      end
      if (wr_div && avs_byteenable[0]) begin
        div_reg.sys_div <= avs_writedata[`SYS_DIV_LSB +: 4];
        div_reg.core_div <= avs_writedata[`CORE_DIV_LSB +: 2];
      end
      if (wr_reg && avs_byteenable[0]) begin
        reg_switch_reg <= avs_writedata[`REG_SWITCH_LSB +: 2];
        reg_level_reg <= avs_writedata[`REG_LEVEL_LSB +: 4];
      end
      if (mode_reg == MODE_HIBERNATE && (rtc_wakeup_i || reset_pin_i)) begin
        reg_switch_reg <= `REG_SWITCH_RESET;
      end
    end
  end

  // Power mode sequencing. Software picks the resumed mode through the bypass bit.
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MODE_FULL_ON, MODE_ACTIVE: begin
        if (wr_reg && avs_byteenable[0] && avs_writedata[1:0] == 2'h0) begin
          mode_next = MODE_HIBERNATE;
        end else if (wr_pwr && avs_byteenable[0] && avs_writedata[`PWR_DEEP_BIT]) begin
          mode_next = MODE_DEEP_SLEEP;
        end else if (wr_pwr && avs_byteenable[0] && avs_writedata[`PWR_SLEEP_BIT]) begin
          mode_next = MODE_SLEEP;
        end else if (mode_reg == MODE_ACTIVE && !pll_reg.bypass && !pll_reg.disable_pll) begin
          mode_next = MODE_RELOCK;
        end else if (mode_reg == MODE_FULL_ON && pll_reg.bypass) begin
          mode_next = MODE_ACTIVE;
        end else if (relock_req && !pll_reg.bypass) begin
          mode_next = MODE_RELOCK;
        end
      end
      MODE_SLEEP: begin
        if (wakeup_i) begin
          mode_next = pll_reg.bypass ? MODE_ACTIVE : MODE_FULL_ON;
        end
      end
      MODE_DEEP_SLEEP: begin
        if (reset_interrupt_i) begin
          mode_next = pll_reg.bypass ? MODE_ACTIVE : MODE_RELOCK;
        end
      end
      MODE_HIBERNATE: begin
        if (rtc_wakeup_i || reset_pin_i) begin
          mode_next = MODE_RELOCK;
        end
      end
      MODE_RELOCK: begin
        if (lock_count_reg >= 32'(LOCK_CYCLES) - 32'd1) begin
          mode_next = MODE_FULL_ON;
        end
      end
      default: mode_next = MODE_FULL_ON;
    endcase
  end

  // Mode register, lock timer and the applied multiplier.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_reg <= MODE_FULL_ON;
      lock_count_reg <= 32'h0;
      mult_applied_reg <= `PLL_MULT_RESET;
      boot_reg <= 1'b0;
    end else if (ce_i) begin
      mode_reg <= mode_next;
      lock_count_reg <= (mode_reg == MODE_RELOCK) ? lock_count_reg + 32'd1 : 32'h0;
      boot_reg <= (mode_reg == MODE_HIBERNATE) && (mode_next == MODE_RELOCK);
      if (mode_reg == MODE_RELOCK && mode_next == MODE_FULL_ON) begin
        mult_applied_reg <= pll_reg.mult;
      end
    end
  end

  // Clock gating per mode; active mode runs both clocks at input rate.
  logic pll_out_run;
  logic core_run;
  logic sys_run;
  logic [3:0] core_ratio;
  logic [3:0] sys_ratio;
  logic core_tick;
  logic sys_tick;
  assign pll_out_run = (mode_reg == MODE_FULL_ON) || (mode_reg == MODE_SLEEP);
  assign core_run = (mode_reg == MODE_FULL_ON) || (mode_reg == MODE_ACTIVE);
  assign sys_run = core_run || (mode_reg == MODE_SLEEP);
  assign core_ratio = (mode_reg == MODE_ACTIVE) ? 4'h1 : (4'h1 << div_reg.core_div);
  assign sys_ratio = (mode_reg == MODE_ACTIVE) ? 4'h1 : div_reg.sys_div;

  clock_enable_divider #(
    .DIV_W(4)
  ) core_div_u (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .run_i(core_run),
    .ratio_i(core_ratio),
    .tick_o(core_tick)
  );

  clock_enable_divider #(
    .DIV_W(4)
  ) sys_div_u (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .run_i(sys_run),
    .ratio_i(sys_ratio),
    .tick_o(sys_tick)
  );

  // Voltage in millivolts, kept in a flop so the data output is registered.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      level_mv_reg <= 12'h0;
    end else if (ce_i) begin
      level_mv_reg <= 12'(`REG_BASE_MV + `REG_STEP_MV * int'(reg_level_reg));
    end
  end

  assign core_clock_en_o = core_tick;
  assign sys_clock_en_o = sys_tick;
  assign peripheral_clock_en_o = sys_tick;
  assign vco_mult_o = (mode_reg == MODE_ACTIVE) ? 6'(VCO_PER_INPUT) : mult_applied_reg;
  assign pll_bypass_o = (mode_reg == MODE_ACTIVE) || !pll_out_run;
  assign regulator_on_o = (mode_reg != MODE_HIBERNATE);
  assign core_level_code_o = reg_level_reg;
  assign core_level_mv_o = regulator_on_o ? level_mv_reg : 12'h0;
  assign boot_start_o = boot_reg;
  assign power_mode_o = 3'(mode_reg);
endmodule
`default_nettype wire

// file: rtl/clk_power_pkg.sv
// Types shared by the clock generation and power-state control block.
package clk_power_pkg;
  typedef enum logic [2:0] {
    MODE_FULL_ON,
    MODE_ACTIVE,
    MODE_SLEEP,
    MODE_DEEP_SLEEP,
    MODE_HIBERNATE,
    MODE_RELOCK
  } power_mode_t;
  typedef struct packed {
    logic [5:0] mult;
    logic bypass;
    logic disable_pll;
  } pll_cfg_t;
  typedef struct packed {
    logic [1:0] core_div;
    logic [3:0] sys_div;
  } div_cfg_t;
  typedef struct packed {
    logic core_clock_en;
    logic sys_clock_en;
    logic pll_running;
    logic regulator_on;
  } clock_state_t;
endpackage

// file: rtl/clock_enable_divider.sv
// Glitch-free clock-enable divider that reloads its ratio only at a period boundary.
`timescale 1ns/10ps
`default_nettype none
module clock_enable_divider #(
  parameter int DIV_W = 4
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [DIV_W-1:0] ratio_i,
  output logic tick_o
);
  logic [DIV_W-1:0] count_reg;
  logic [DIV_W-1:0] ratio_reg;
  logic boundary;
  logic [DIV_W-1:0] ratio_safe;
  // A ratio of zero is treated as one so the output never stalls for good.
  assign ratio_safe = (ratio_i == '0) ? DIV_W'(1) : ratio_i;
  assign boundary = (count_reg == ratio_reg - DIV_W'(1));
  assign tick_o = run_i && boundary;
  // The new ratio is only taken at the end of a period, so no short pulse appears.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= '0;
      ratio_reg <= DIV_W'(1);
    end else if (ce_i && run_i) begin
      if (boundary) begin
        count_reg <= '0;
        ratio_reg <= ratio_safe;
      end else begin
        count_reg <= count_reg + DIV_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// file: test/clk_power_ctrl_assertions.sv
// Concurrent checks on the clock and power controller ports.
`timescale 1ns/10ps
`default_nettype none
module clk_power_ctrl_assertions
  import clk_power_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic core_clock_en_o,
  input wire logic sys_clock_en_o,
  input wire logic peripheral_clock_en_o,
  input wire logic [5:0] vco_mult_o,
  input wire logic regulator_on_o,
  input wire logic [3:0] core_level_code_o,
  input wire logic [11:0] core_level_mv_o,
  input wire logic boot_start_o,
  input wire logic [2:0] power_mode_o
);
  // One clock domain, so clock and reset are given once for all checks.
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // A request taken while the wait is still asserted.
  sequence taken_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // The edge at which hibernate is left; the past term guards the first edge.
  sequence hib_left_s;
    $past(power_mode_o) == MODE_HIBERNATE && power_mode_o != MODE_HIBERNATE;
  endsequence
  periph_from_sys_a: assert property (peripheral_clock_en_o == sys_clock_en_o)
    else $error("peripheral enable differs from system enable");
  level_step_a: assert property ($past(reset_n_i) && regulator_on_o && $past(regulator_on_o) &&
    $stable(core_level_code_o) |-> core_level_mv_o == 12'(650 + 50 * core_level_code_o))
    else $error("core level millivolts do not follow the level code");
  active_unity_a: assert property ($past(power_mode_o) == MODE_ACTIVE &&
    power_mode_o == MODE_ACTIVE |-> vco_mult_o == 6'h01)
    else $error("applied multiplier is not one in active mode");
  hib_stops_a: assert property ($past(power_mode_o) == MODE_HIBERNATE &&
    power_mode_o == MODE_HIBERNATE |-> !core_clock_en_o && !sys_clock_en_o && !regulator_on_o)
    else $error("clock or regulator running in hibernate");
  one_wait_a: assert property (taken_s |=> !avs_waitrequest)
    else $error("answer not given one cycle after the take");
  answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait stays low for more than one cycle");
  boot_wake_a: assert property (hib_left_s |-> ##[0:1] boot_start_o)
    else $error("no boot start after leaving hibernate");
  boot_single_a: assert property (boot_start_o |=> !boot_start_o)
    else $error("boot start longer than one cycle");
endmodule
bind clk_power_ctrl clk_power_ctrl_assertions u_chk (.mclk_i, .reset_n_i, .avs_read, .avs_write,
  .avs_waitrequest, .core_clock_en_o, .sys_clock_en_o, .peripheral_clock_en_o, .vco_mult_o,
  .regulator_on_o, .core_level_code_o, .core_level_mv_o, .boot_start_o, .power_mode_o);
`default_nettype wire

// file: test/pll_clock_divider_power_wake_test.sv
// Self-checking bench for the clock generation and power-state controller.
`include "clk_power_consts.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module pll_clock_divider_power_wake_test
  import clk_power_pkg::*;
;
  logic mclk_i, reset_n_i, avs_read, avs_write, wakeup_i, reset_interrupt_i, rtc_wakeup_i;
  logic reset_pin_i, avs_waitrequest, core_clock_en_o, sys_clock_en_o, pll_bypass_o;
  logic regulator_on_o, boot_start_o, peripheral_clock_en_o;
  logic [3:0] avs_address, core_level_code_o, sd, lv;
  logic [31:0] avs_writedata, avs_readdata, e_r;
  logic [31:0] exp_q[$];
  logic [5:0] vco_mult_o, mult;
  logic [11:0] core_level_mv_o;
  logic [2:0] power_mode_o;
  int fails = 0, checked = 0, boots = 0, n, m;
  // Short lock count keeps the relock walks brief.
  clk_power_ctrl #(.LOCK_CYCLES(8)) u_dut (.mclk_i, .reset_n_i, .ce_i(1'b1), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .wakeup_i, .reset_interrupt_i, .rtc_wakeup_i, .reset_pin_i,
    .core_clock_en_o, .sys_clock_en_o, .peripheral_clock_en_o, .vco_mult_o, .pll_bypass_o,
    .regulator_on_o, .core_level_code_o, .core_level_mv_o, .boot_start_o, .power_mode_o);
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // Read data stand at the edge where waitrequest is sampled low, so the note is taken there.
  always @(posedge mclk_i) begin
    if (avs_read && !avs_waitrequest && exp_q.size() > 0) begin
      e_r = exp_q.pop_front();
      `CHK(avs_readdata, e_r)
    end
  end
  always @(posedge mclk_i) begin
    if (boot_start_o === 1'b1) boots <= boots + 1;
  end
  task automatic summarize();
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // The request stands until an edge samples waitrequest low, and is released at that edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge mclk_i); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_mode(input logic [2:0] md);
    int k;
    k = 0;
    while (power_mode_o !== md && k < 100) begin
      @(negedge mclk_i);
      k++;
    end
    `CHK(power_mode_o, md)
  endtask
  // Cycles between two enable pulses of the chosen divided clock.
  task automatic gap(input logic core, output int cnt);
    cnt = 0;
    do @(negedge mclk_i); while ((core ? core_clock_en_o : sys_clock_en_o) !== 1'b1);
    do begin
      @(negedge mclk_i);
      cnt++;
    end while ((core ? core_clock_en_o : sys_clock_en_o) !== 1'b1);
    if (!core) `CHK(peripheral_clock_en_o, 1'b1)
  endtask
  initial begin
    {avs_read, avs_write, wakeup_i, reset_interrupt_i, rtc_wakeup_i, reset_pin_i} = 6'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    reset_n_i = 1'b0;
    void'($urandom(32'h7AFBAAF9));
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(4'h0, 32'h0000000A);
    rd(4'h1, 32'h00000005);
    rd(4'h2, 32'h000000B1);
    rd(4'hF, `ADDR_UNMAPPED_DATA);
    for (int i = 0; i < 4; i++) begin
      mult = (i == 3) ? 6'($urandom_range(62, 2)) : (i == 2) ? 6'h3F : 6'(i);
      bus(1'b1, 4'h0, {26'h0, mult});
      bus(1'b1, 4'h3, 32'h00000004);
      wait_mode(MODE_RELOCK);
      wait_mode(MODE_FULL_ON);
      if (mult == 6'h00) mult = 6'h01;
      `CHK(vco_mult_o, mult)
      rd(4'h4, 32'(mult) << 6);
    end
    // Every core code, and system codes at both ends plus random ones.
    for (int c = 0; c < 4; c++) begin
      sd = (c == 0) ? 4'h1 : (c == 3) ? 4'hF : 4'($urandom_range(14, 2));
      bus(1'b1, 4'h1, {26'h0, 2'(c), sd});
      gap(1'b1, n);
      gap(1'b1, n);
      `CHK(n, 1 << c)
      gap(1'b0, n);
      gap(1'b0, n);
      `CHK(n, int'(sd))
      `CHK(power_mode_o, MODE_FULL_ON)
    end
    for (int i = 0; i < 3; i++) begin
      lv = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom_range(14, 1));
      bus(1'b1, 4'h2, {24'h0, lv, 4'h1});
      repeat (2) @(negedge mclk_i);
      `CHK(core_level_mv_o, 12'(`REG_BASE_MV + `REG_STEP_MV * lv))
      `CHK(core_level_code_o, lv)
    end
    // Hibernate, left once by the timer wake and once by the reset pin.
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 4'h2, 32'h000000B0);
      wait_mode(MODE_HIBERNATE);
      `CHK(regulator_on_o, 1'b0)
      m = boots;
      @(posedge mclk_i);
      if (s == 0) rtc_wakeup_i <= 1'b1;
      else reset_pin_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      rtc_wakeup_i <= 1'b0;
      reset_pin_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      `CHK(boots, m + 1)
      rd(4'h2, 32'h000000B1);
    end
    // Sleep and deep sleep, each left with the bypass bit clear and then set.
    for (int b = 0; b < 2; b++) begin
      for (int d = 0; d < 2; d++) begin
        bus(1'b1, 4'h0, {23'h0, 1'(b), 2'b00, mult});
        wait_mode(b ? MODE_ACTIVE : MODE_FULL_ON);
        bus(1'b1, 4'h3, d ? 32'h2 : 32'h1);
        wait_mode(d ? MODE_DEEP_SLEEP : MODE_SLEEP);
        @(posedge mclk_i);
        if (d) reset_interrupt_i <= 1'b1;
        else wakeup_i <= 1'b1;
        if (d && !b) wait_mode(MODE_RELOCK);
        wait_mode(b ? MODE_ACTIVE : MODE_FULL_ON);
        @(posedge mclk_i);
        reset_interrupt_i <= 1'b0;
        wakeup_i <= 1'b0;
      end
    end
    // A multiplier written while bypassed waits for full-on.
    mult = 6'($urandom_range(63, 2));
    bus(1'b1, 4'h0, {23'h0, 1'b1, 2'b00, mult});
    gap(1'b0, n);
    `CHK(n, 1)
    `CHK(vco_mult_o, 6'h01)
    `CHK(pll_bypass_o, 1'b1)
    bus(1'b1, 4'h0, {26'h0, mult});
    wait_mode(MODE_RELOCK);
    wait_mode(MODE_FULL_ON);
    `CHK(vco_mult_o, mult)
    `CHK(pll_bypass_o, 1'b0)
    summarize();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge mclk_i);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
